// ==== hw/out_hold_if.sv ====
// Purpose: carries start and hold signals to the output timer
// Assumes: single clock domain
// Notes:   start pulses are one cycle long
`timescale 1ns/1ps
interface out_hold_if;
    logic       start_ok;
    logic       start_err;
    logic       release_hold;
    logic [1:0] time_sel;
    logic       normal;
    logic       error;
    modport ctl (output start_ok, start_err, release_hold, time_sel,
                 input  normal, error);
    modport tmr (input  start_ok, start_err, release_hold, time_sel,
                 output normal, error);
endinterface

// ==== hw/out_hold_timer.sv ====
// Purpose: holds normal or error output for the selected time
// Assumes: time_sel stable after power-up capture
// Notes:   continuous hold ends only on release_hold or on a new start_ok or start_err
`timescale 1ns/1ps
module out_hold_timer
    import tag_io_pkg::*;
#(
    parameter int SHORT_CYC = OUT_SHORT_CYC,
    parameter int LONG_CYC  = OUT_LONG_CYC
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // control side
    out_hold_if.tmr   hold
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic             normal;
        logic             error;
        logic             cont;
    } tmr_s;

    tmr_s tmr_reg;
    tmr_s tmr_next;

    always_comb begin
        tmr_next = tmr_reg;
        if (hold.start_ok || hold.start_err) begin
            tmr_next.normal = hold.start_ok;
            tmr_next.error  = hold.start_err;
            tmr_next.cont   = (hold.time_sel == OT_CONT);
            tmr_next.cnt    = (hold.time_sel == OT_50MS) ?
                              TMR_W'(LONG_CYC) : TMR_W'(SHORT_CYC);
        end else if (tmr_reg.normal || tmr_reg.error) begin
            if (tmr_reg.cont) begin
                if (hold.release_hold) begin
                    tmr_next.normal = 1'b0;
                    tmr_next.error  = 1'b0;
                end
            end else if (tmr_reg.cnt == TMR_W'(1)) begin
                tmr_next.normal = 1'b0;
                tmr_next.error  = 1'b0;
            end else begin
                tmr_next.cnt = tmr_reg.cnt - TMR_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign hold.normal = tmr_reg.normal;
    assign hold.error  = tmr_reg.error;

    // ****************************************
    // checks
    // ****************************************
    property p_ok_not_err;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        hold.start_ok |=> hold.normal && !hold.error;
    endproperty
    a_ok_not_err: assert property (p_ok_not_err)
        else $error("normal did not follow success");

    property p_cont_holds;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (tmr_reg.cont && hold.error && !hold.release_hold
         && !hold.start_ok && !hold.start_err) |=> hold.error;
    endproperty
    a_cont_holds: assert property (p_cont_holds)
        else $error("continuous error dropped early");
endmodule

// ==== hw/tag_byte_access_host_io.sv ====
// Purpose: host-side parallel port of an 8-bit tag read/write amplifier
// Assumes: tag link answers each request with one done or fail pulse
// Notes:   settings caught once after reset release
`timescale 1ns/1ps
module tag_byte_access_host_io
    import tag_io_pkg::*;
#(
    parameter int DELAY_CYC = NORMAL_DELAY_CYC,
    parameter int SHORT_CYC = OUT_SHORT_CYC,
    parameter int LONG_CYC  = OUT_LONG_CYC
) (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // switches
    input  wire logic [7:0] addr_sw_i,
    input  wire logic       auto_mode_i,
    input  wire logic       verify_mode_i,
    input  wire logic [1:0] write_mode_i,
    input  wire logic [1:0] out_time_i,
    // host discrete lines
    input  wire logic [7:0] host_input_lines_i,
    input  wire logic       write_sel_i,
    input  wire logic       trigger_i,
    input  wire logic       inhibit_i,
    output logic      [7:0] result_output_lines_o,
    output logic            normal_o,
    output logic            error_o,
    // tag link
    input  wire logic       tag_present_i,
    input  wire logic       tag_done_i,
    input  wire logic       tag_fail_i,
    input  wire logic [7:0] tag_rdata_i,
    output logic            tag_req_o,
    output logic            tag_write_o,
    output logic      [7:0] tag_addr_o,
    output logic      [7:0] tag_wdata_o,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE, S_RD, S_WR, S_CHK, S_DLY
    } state_e;

    typedef struct packed {
        state_e           st;
        logic [7:0]       result;
        logic [7:0]       tag_val;
        logic [7:0]       host_val;
        logic [7:0]       new_val;
        logic [TMR_W-1:0] cnt;
        logic             armed;
        logic             inh_q;
        logic             trg_q;
        logic             cfg_done;
        logic             cfg_auto;
        logic             cfg_verify;
        logic [1:0]       cfg_wmode;
        logic [1:0]       cfg_time;
        logic             is_write;
        logic             soft_trig;
        logic             req;
        logic             req_we;
        logic [7:0]       rdata;
        logic             start_ok;
        logic             start_err;
        logic             rel;
    } io_s;

    io_s io_reg;
    io_s io_next;

    out_hold_if hold ();

    logic trg_evt;

    function automatic logic [7:0] merge(input logic [1:0] mode,
                                         input logic [7:0] cur,
                                         input logic [7:0] mask);
        case (mode)
            WM_SET:   merge = cur | mask;
            WM_CLEAR: merge = cur & ~mask;
            default:  merge = mask;
        endcase
    endfunction

    assign trg_evt = (trigger_i & ~io_reg.trg_q) | io_reg.soft_trig;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        io_next           = io_reg;
        io_next.start_ok  = 1'b0;
        io_next.start_err = 1'b0;
        io_next.soft_trig = 1'b0;
        io_next.rdata     = 8'h00;
        io_next.trg_q     = trigger_i;
        io_next.inh_q     = inhibit_i;
        // later changes of the mode and time switches are ignored; addr_sw_i is used live
        if (!io_reg.cfg_done) begin
            io_next.cfg_done   = 1'b1;
            io_next.cfg_auto   = auto_mode_i;
            io_next.cfg_verify = verify_mode_i;
            io_next.cfg_wmode  = write_mode_i;
            io_next.cfg_time   = out_time_i;
        end
        if (reg_wr_i && reg_addr_i == REG_CONTROL) begin
            io_next.soft_trig = reg_wdata_i[CTRL_SOFT_TRIG_BIT];
            if (reg_wdata_i[CTRL_REARM_BIT]) begin
                io_next.armed = 1'b1;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == REG_STATUS) begin
                io_next.rdata = {1'b0, io_reg.st, io_reg.armed,
                                 tag_present_i, error_o, normal_o};
            end else if (reg_addr_i == REG_DATA) begin
                io_next.rdata = io_reg.tag_val;
            end else if (reg_addr_i == REG_CONFIG) begin
                io_next.rdata = {1'b0, io_reg.cfg_done, io_reg.cfg_time,
                                 io_reg.cfg_wmode, io_reg.cfg_verify,
                                 io_reg.cfg_auto};
            end else begin
                io_next.rdata = 8'h00;
            end
        end
        io_next.rel = io_reg.cfg_auto ? (inhibit_i & ~io_reg.inh_q)
                                      : trg_evt;
        if (!tag_present_i || (io_reg.inh_q && !inhibit_i)) begin
            io_next.armed = 1'b1;
        end
        case (io_reg.st)
            S_IDLE: begin
                if (io_reg.cfg_done && !inhibit_i &&
                    (io_reg.cfg_auto ? (io_reg.armed && tag_present_i)
                                     : trg_evt)) begin
                    if (!io_reg.cfg_auto) begin
                        io_next.result = RESULT_RST;
                    end
                    io_next.armed    = 1'b0;
                    io_next.host_val = host_input_lines_i;
                    io_next.is_write = write_sel_i;
                    if (!tag_present_i) begin
                        io_next.result    = RESULT_RST;
                        io_next.start_err = 1'b1;
                    end else begin
                        io_next.req    = 1'b1;
                        io_next.req_we = 1'b0;
                        io_next.st     = S_RD;
                    end
                end
            end
            S_RD: begin
                if (tag_fail_i) begin
                    io_next.req       = 1'b0;
                    io_next.result    = RESULT_RST;
                    io_next.start_err = 1'b1;
                    io_next.st        = S_IDLE;
                end else if (tag_done_i) begin
                    io_next.tag_val = tag_rdata_i;
                    io_next.req     = 1'b0;
                    if (io_reg.is_write) begin
                        // bit modes reuse the byte just read
                        io_next.new_val = merge(io_reg.cfg_wmode,
                                                tag_rdata_i,
                                                io_reg.host_val);
                        io_next.req     = 1'b1;
                        io_next.req_we  = 1'b1;
                        io_next.st      = S_WR;
                    end else if (io_reg.cfg_verify) begin
                        io_next.result   = (tag_rdata_i == io_reg.host_val)
                                           ? VERIFY_MATCH
                                           : VERIFY_DIFF;
                        io_next.start_ok = 1'b1;
                        io_next.st       = S_IDLE;
                    end else begin
                        io_next.result = tag_rdata_i;
                        io_next.cnt    = TMR_W'(DELAY_CYC);
                        io_next.st     = S_DLY;
                    end
                end
            end
            S_WR: begin
                if (tag_fail_i) begin
                    io_next.req       = 1'b0;
                    io_next.result    = RESULT_RST;
                    io_next.start_err = 1'b1;
                    io_next.st        = S_IDLE;
                end else if (tag_done_i) begin
                    io_next.req_we = 1'b0;
                    io_next.st     = S_CHK;
                end
            end
            S_CHK: begin
                if (tag_done_i && tag_rdata_i == io_reg.new_val) begin
                    io_next.req      = 1'b0;
                    io_next.result   = io_reg.new_val;
                    io_next.tag_val  = tag_rdata_i;
                    io_next.start_ok = 1'b1;
                    io_next.st       = S_IDLE;
                end else if (tag_done_i || tag_fail_i) begin
                    io_next.req       = 1'b0;
                    io_next.result    = RESULT_RST;
                    io_next.start_err = 1'b1;
                    io_next.st        = S_IDLE;
                end
            end
            S_DLY: begin
                if (io_reg.cnt == TMR_W'(1)) begin
                    io_next.start_ok = 1'b1;
                    io_next.st       = S_IDLE;
                end else begin
                    io_next.cnt = io_reg.cnt - TMR_W'(1);
                end
            end
            default: begin
                io_next.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_reg       <= '0;
            io_reg.st    <= S_IDLE;
            io_reg.armed <= 1'b1;
        end else begin
            io_reg <= io_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hold.start_ok     = io_reg.start_ok;
    assign hold.start_err    = io_reg.start_err;
    assign hold.release_hold = io_reg.rel;
    assign hold.time_sel     = io_reg.cfg_time;

    out_hold_timer #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .hold      (hold.tmr)
    );

    // gated without a register so inhibit acts at once
    assign result_output_lines_o = inhibit_i ? 8'h00 : io_reg.result;
    assign normal_o    = hold.normal;
    assign error_o     = hold.error;
    assign tag_req_o   = io_reg.req;
    assign tag_write_o = io_reg.req_we;
    assign tag_addr_o  = addr_sw_i;
    assign tag_wdata_o = io_reg.new_val;
    assign reg_rdata_o = io_reg.rdata;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_ok_out;
        io_reg.start_ok ##1 normal_o;
    endsequence

    sequence s_err_out;
        io_reg.start_err && io_reg.result == 8'h00 ##1 error_o;
    endsequence

    property p_inhibit_zero;
        inhibit_i |-> result_output_lines_o == 8'h00;
    endproperty
    a_inhibit_zero: assert property (p_inhibit_zero)
        else $error("result lines not cleared by inhibit");

    property p_delay_end;
        (io_reg.st == S_DLY && io_reg.cnt == TMR_W'(1)) |=> s_ok_out;
    endproperty
    a_delay_end: assert property (p_delay_end)
        else $error("normal not raised after read delay");

    property p_read_data;
        (io_reg.st == S_RD && tag_done_i && !tag_fail_i &&
         !io_reg.is_write && !io_reg.cfg_verify)
        |=> io_reg.st == S_DLY && io_reg.result == $past(tag_rdata_i);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read byte not placed on results");

    property p_verify_code;
        (io_reg.st == S_RD && tag_done_i && !tag_fail_i &&
         !io_reg.is_write && io_reg.cfg_verify)
        |=> (io_reg.result == (($past(tag_rdata_i) == io_reg.host_val)
             ? VERIFY_MATCH : VERIFY_DIFF)) ##0 s_ok_out;
    endproperty
    a_verify_code: assert property (p_verify_code)
        else $error("compare result code wrong");

    property p_fail_err;
        (io_reg.st != S_IDLE && io_reg.st != S_DLY && tag_fail_i)
        |=> s_err_out;
    endproperty
    a_fail_err: assert property (p_fail_err)
        else $error("tag failure did not raise error");

    property p_no_tag;
        (io_reg.st == S_IDLE && io_reg.cfg_done && !io_reg.cfg_auto &&
         !inhibit_i && trg_evt && !tag_present_i) |=> s_err_out;
    endproperty
    a_no_tag: assert property (p_no_tag)
        else $error("missing tag not reported");

    property p_rmw;
        (io_reg.st == S_WR)
        |-> tag_wdata_o == merge(io_reg.cfg_wmode, io_reg.tag_val,
                                 io_reg.host_val) && tag_write_o;
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("write value not merged from tag byte");

    property p_check_fail;
        (io_reg.st == S_CHK && tag_done_i && !tag_fail_i &&
         tag_rdata_i != io_reg.new_val) |=> s_err_out;
    endproperty
    a_check_fail: assert property (p_check_fail)
        else $error("readback mismatch not an error");

    property p_cfg_frozen;
        io_reg.cfg_done |=> $stable(io_reg.cfg_time) &&
                            $stable(io_reg.cfg_wmode) &&
                            $stable(io_reg.cfg_auto);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("settings changed after capture");

    property p_auto_once;
        (io_reg.st == S_IDLE && io_reg.cfg_auto && !io_reg.armed)
        |=> io_reg.st == S_IDLE;
    endproperty
    a_auto_once: assert property (p_auto_once)
        else $error("present tag accessed twice");
endmodule

// ==== hw/tag_io_pkg.sv ====
// Purpose: shared constants for the tag byte access port
// Assumes: 200 MHz reference clock
// Notes:   timing counts derive from printed times
package tag_io_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ          = 200;
    localparam int NORMAL_DELAY_US  = 3000;
    localparam int OUT_SHORT_US     = 10000;
    localparam int OUT_LONG_US      = 50000;
    localparam int NORMAL_DELAY_CYC = NORMAL_DELAY_US * CLK_MHZ;
    localparam int OUT_SHORT_CYC    = OUT_SHORT_US * CLK_MHZ;
    localparam int OUT_LONG_CYC     = OUT_LONG_US * CLK_MHZ;
    localparam int TMR_W            = 24;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_DATA    = 8'h04;
    localparam logic [7:0] REG_CONFIG  = 8'h08;
    localparam logic [7:0] REG_CONTROL = 8'h0C;
    localparam int CTRL_SOFT_TRIG_BIT  = 0;
    localparam int CTRL_REARM_BIT      = 1;

    // ****************************************
    // settings and codes
    // ****************************************
    localparam logic [1:0] OT_10MS      = 2'h0;
    localparam logic [1:0] OT_50MS      = 2'h1;
    localparam logic [1:0] OT_CONT      = 2'h2;
    localparam logic [1:0] WM_BYTE      = 2'h0;
    localparam logic [1:0] WM_SET       = 2'h1;
    localparam logic [1:0] WM_CLEAR     = 2'h2;
    localparam logic [7:0] VERIFY_MATCH = 8'h01;
    localparam logic [7:0] VERIFY_DIFF  = 8'h80;
    localparam logic [7:0] RESULT_RST   = 8'h00;
endpackage

// ==== verification/tag_model.sv ====
// Purpose: behavioural tag on the far side of the tag link
// Assumes: one request at a time, held until done or fail
// Notes:   latency set per access; stale read data inverts each cycle
`timescale 1ns/1ps
module tag_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // request side
    input  wire logic       req_i,
    input  wire logic       write_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [3:0] lat_i,
    input  wire logic       fail_arm_i,
    // answer side
    output logic            done_o,
    output logic            fail_o,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [256];
    logic [3:0] cnt_reg;

    // plain always: the bench presets bytes of mem as well
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 4'h0;
            done_o  <= 1'b0;
            fail_o  <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            done_o  <= 1'b0;
            fail_o  <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i && !done_o && !fail_o) begin
                if (cnt_reg >= lat_i) begin
                    cnt_reg <= 4'h0;
                    if (fail_arm_i) begin
                        fail_o <= 1'b1;
                    end else begin
                        done_o <= 1'b1;
                        if (write_i) begin
                            mem[addr_i] <= wdata_i;
                        end else begin
                            rdata_o <= mem[addr_i];
                        end
                    end
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end else begin
                cnt_reg <= 4'h0;
            end
        end
    end
endmodule

// ==== verification/tb_tag_byte_access_host_io.sv ====
// Purpose: self-checking bench of the tag byte access host port
// Assumes: shortened counts DELAY 20, SHORT 10, LONG 30
// Notes:   settings flipped after each reset to show they are ignored
`timescale 1ns/1ps
module tb_tag_byte_access_host_io;
    import tag_io_pkg::*;
    localparam int D = 20;
    localparam int S = 10;
    localparam int L = 30;
    logic ref_clk = 1'b0, rst_n = 1'b0, auto = 1'b0, verify = 1'b0;
    logic [1:0] wmode = 2'h0, otime = 2'h0;
    logic [7:0] addr = 8'h00, host = 8'h00, res, taddr, twd, trd, rdo;
    logic wsel = 1'b0, trig = 1'b0, inhib = 1'b0, present = 1'b1;
    logic normal, err, treq, twr, tdone, tfail, farm = 1'b0;
    logic [7:0] raddr = 8'h00, rwd = 8'h00, cur, d;
    logic rwr = 1'b0, rrd = 1'b0;
    logic [3:0] lat = 4'h2;
    logic [31:0] seed = 32'h340A;
    int bad_count = 0, samples_checked = 0, c;
    int hold_exp = S;

    always #2.5 ref_clk = ~ref_clk;

    tag_byte_access_host_io #(.DELAY_CYC(D), .SHORT_CYC(S),
        .LONG_CYC(L)) i_dut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_sw_i(addr),
        .auto_mode_i(auto), .verify_mode_i(verify),
        .write_mode_i(wmode), .out_time_i(otime),
        .host_input_lines_i(host), .write_sel_i(wsel),
        .trigger_i(trig), .inhibit_i(inhib),
        .result_output_lines_o(res), .normal_o(normal), .error_o(err),
        .tag_present_i(present), .tag_done_i(tdone),
        .tag_fail_i(tfail), .tag_rdata_i(trd), .tag_req_o(treq),
        .tag_write_o(twr), .tag_addr_o(taddr), .tag_wdata_o(twd),
        .reg_addr_i(raddr), .reg_wdata_i(rwd), .reg_wr_i(rwr),
        .reg_rd_i(rrd), .reg_rdata_o(rdo));

    tag_model i_tag (.clk_i(ref_clk), .rst_n_i(rst_n), .req_i(treq),
        .write_i(twr), .addr_i(taddr), .wdata_i(twd), .lat_i(lat),
        .fail_arm_i(farm), .done_o(tdone), .fail_o(tfail),
        .rdata_o(trd));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] merge(input logic [1:0] m,
                                         input logic [7:0] cv, dv);
        if (m == WM_SET) return cv | dv;
        if (m == WM_CLEAR) return cv & ~dv;
        return dv;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
            bad_count++;
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // settings flipped after capture; behaviour must follow the first
    task automatic boot(input logic a, v, input logic [1:0] w, t);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        auto <= a;
        verify <= v;
        wmode <= w;
        otime <= t;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        auto <= ~a;
        verify <= ~v;
        wmode <= ~w;
        otime <= ~t;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        raddr <= a;
        rrd <= 1'b1;
        @(posedge ref_clk);
        rrd <= 1'b0;
        #1 v = rdo;
    endtask

    task automatic prep;
        seed = xs(seed);
        addr <= seed[7:0];
        cur = seed[15:8];
        i_tag.mem[seed[7:0]] = cur;
        lat <= 4'h2 + seed[18:16];
    endtask

    // one access: trigger pin or soft trigger, then outcome and timing
    task automatic run(input logic w, sw, input logic [7:0] hv, er,
                       input logic ee, input int l);
        int n, td, hi;
        @(posedge ref_clk);
        host <= hv;
        wsel <= w;
        if (sw) begin
            raddr <= REG_CONTROL;
            rwd <= 8'h01;
            rwr <= 1'b1;
        end else begin
            trig <= 1'b1;
        end
        @(posedge ref_clk);
        trig <= 1'b0;
        rwr <= 1'b0;
        td = 0;
        n = 0;
        while (n < 3000 && normal !== 1'b1 && err !== 1'b1) begin
            @(posedge ref_clk);
            #1 n++;
            if (tdone === 1'b1) td = n;
        end
        chk("finished", 1, n < 3000);
        chk("error", ee, err);
        chk("result", er, res);
        if (l > 0) chk("latency", l, n - td);
        hi = 0;
        while ((normal === 1'b1 || err === 1'b1) && hi < 100) begin
            hi++;
            @(posedge ref_clk);
            #1;
        end
        chk("width", hold_exp, hi);
    endtask

    task automatic count_req(output int k);
        logic p;
        k = 0;
        p = treq;
        repeat (90) begin
            @(posedge ref_clk);
            #1 if (treq === 1'b1 && !p) k++;
            p = treq;
        end
    endtask

    initial begin
        #(20000 * 5);
        bad_count++;
        test_done;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        boot(1'b0, 1'b0, WM_BYTE, OT_10MS);
        repeat (3) begin
            prep;
            run(1'b0, 1'b0, 8'h00, cur, 1'b0, D + 2);
            chk("held", cur, res);
            @(posedge ref_clk) inhib <= 1'b1;
            @(posedge ref_clk);
            #1 chk("inhibit", 8'h00, res);
            @(posedge ref_clk) inhib <= 1'b0;
            rd(REG_DATA, d);
            chk("data reg", cur, d);
            rd(8'h10, d);
            chk("unmapped", 8'h00, d);
        end
        prep;
        run(1'b0, 1'b1, 8'h00, cur, 1'b0, D + 2);
        prep;
        farm <= 1'b1;
        run(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 0);
        farm <= 1'b0;
        present <= 1'b0;
        run(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 0);
        present <= 1'b1;
        boot(1'b0, 1'b1, WM_BYTE, OT_50MS);
        rd(REG_STATUS, d);
        chk("status", 8'h0C, d);
        prep;
        hold_exp = L;
        run(1'b0, 1'b0, cur, VERIFY_MATCH, 1'b0, 2);
        run(1'b0, 1'b0, ~cur, VERIFY_DIFF, 1'b0, 2);
        hold_exp = S;
        for (int m = 0; m < 3; m++) begin
            boot(1'b0, 1'b0, m[1:0], OT_10MS);
            rd(REG_CONFIG, d);
            chk("config", {2'b01, OT_10MS, m[1:0], 2'b00}, d);
            prep;
            seed = xs(seed);
            d = merge(m[1:0], cur, seed[7:0]);
            run(1'b1, 1'b0, seed[7:0], d, 1'b0, 2);
            chk("stored", d, i_tag.mem[addr]);
            prep;
            // fail only the write phase, not the first read
            fork
                run(1'b1, 1'b0, seed[15:8], 8'h00, 1'b1, 0);
                begin
                    wait (treq === 1'b1 && twr === 1'b1);
                    farm <= 1'b1;
                end
            join
            farm <= 1'b0;
            prep;
            // corrupt the stored byte before the readback
            fork
                run(1'b1, 1'b0, seed[15:8], 8'h00, 1'b1, 0);
                begin
                    wait (treq === 1'b1 && twr === 1'b1);
                    wait (twr === 1'b0);
                    i_tag.mem[addr] = ~twd;
                end
            join
        end
        boot(1'b0, 1'b0, WM_BYTE, OT_CONT);
        prep;
        hold_exp = 100;
        run(1'b0, 1'b0, 8'h00, cur, 1'b0, D + 2);
        hold_exp = S;
        @(posedge ref_clk) trig <= 1'b1;
        @(posedge ref_clk) trig <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("released", 0, normal);
        present <= 1'b0;
        boot(1'b1, 1'b0, WM_BYTE, OT_10MS);
        prep;
        repeat (2) begin
            @(posedge ref_clk) present <= 1'b1;
            count_req(c);
            chk("auto accesses", 1, c);
            chk("auto result", cur, res);
            @(posedge ref_clk) present <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        test_done;
    end
endmodule
